// File: hdl/resource_alloc_session_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - an allocation query is answered by opening an exchange session.
// - allocation items are sent only inside an open session.
// - only this side sends the opening message; it opens the session.
// - the opening message carries a message count from 0 to 999.
// - exactly the announced number of items is sent before closing.
// - only this side sends the closing message; it ends the session.
// - closing is sent only after all announced items have gone out.
// - an error message aborts the session at both ends.
// - items reflect the allocation valid at the moment of sending.
// - capacity messages only go out while a session is open.
// - at most one main and one fast-channel capacity message per session.
module resource_alloc_session_ctrl
  import alloc_session_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        query_in,
  input  wire logic        error_in,
  input  wire logic [31:0] error_cause_in,
  input  wire logic [9:0]  item_total_in,
  input  wire logic        item_valid_in,
  input  wire logic [1:0]  item_kind_in,
  input  wire logic [31:0] item_data_in,
  input  wire logic        msg_ready_in,
  output logic             msg_valid_out,
  output logic [1:0]       msg_type_out,
  output logic [9:0]       session_message_count_out,
  output logic [31:0]      msg_data_out,
  output logic             item_taken_out,
  output logic             item_refused_out,
  output logic             session_open_out,
  output logic             aborted_out,
  output logic             mismatch_out
);
  sess_state_t state_ff;
  sess_state_t nxt_state;
  logic        msg_valid_ff;
  logic [1:0]  msg_type_ff;
  logic [9:0]  count_ff;
  logic [31:0] data_ff;
  logic        taken_ff;
  logic        refused_ff;
  logic        open_ff;
  logic        aborted_ff;
  logic        mismatch_ff;
  logic        main_sent_ff;
  logic        fast_sent_ff;

  item_count_if cif();
  item_counter u_count (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .cnt        (cif)
  );

  // a message leaves when the link accepts it, or nothing is pending
  wire out_free = !msg_valid_ff || msg_ready_in;
  wire abort    = error_in && state_ff != ST_IDLE;
  wire [9:0] total_clip = (item_total_in > MAX_COUNT) ? MAX_COUNT
                                                      : item_total_in;
  wire cap_dup = (item_kind_in == KIND_CAP_MAIN && main_sent_ff) ||
                 (item_kind_in == KIND_CAP_FAST && fast_sent_ff);
  wire start_open = state_ff == ST_IDLE && query_in && out_free;
  wire send_item  = state_ff == ST_SEND && item_valid_in && !cif.done &&
                    !cap_dup && out_free && !abort;
  wire send_close = state_ff == ST_SEND && cif.done && out_free && !abort;
  // a duplicate capacity item is refused, not counted
  wire refuse     = state_ff == ST_SEND && item_valid_in && cap_dup &&
                    !abort;

  assign cif.load  = start_open;
  assign cif.value = total_clip;
  assign cif.step  = send_item;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (start_open) nxt_state = ST_OPEN;
      // an error that arrives while the opening message is queued must
      // abort too, or the far end would wait on a session it dropped
      ST_OPEN: begin
        if (abort) nxt_state = ST_IDLE;
        else nxt_state = ST_SEND;
      end
      ST_SEND: begin
        if (abort) nxt_state = ST_IDLE;
        else if (send_close) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_ff     <= ST_IDLE;
      msg_valid_ff <= 1'b0;
      msg_type_ff  <= MSG_OPEN;
      count_ff     <= COUNT_RESET;
      data_ff      <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      if (start_open) begin
        msg_valid_ff <= 1'b1;
        msg_type_ff  <= MSG_OPEN;
        count_ff     <= total_clip;
      end else if (send_item) begin
        msg_valid_ff <= 1'b1;
        msg_type_ff  <= MSG_ITEM;
        data_ff      <= item_data_in;
      end else if (send_close) begin
        msg_valid_ff <= 1'b1;
        msg_type_ff  <= MSG_CLOSE;
      end else if (msg_ready_in || abort) begin
        msg_valid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      open_ff      <= 1'b0;
      main_sent_ff <= 1'b0;
      fast_sent_ff <= 1'b0;
      taken_ff     <= 1'b0;
      refused_ff   <= 1'b0;
      aborted_ff   <= 1'b0;
      mismatch_ff  <= 1'b0;
    end else begin
      open_ff    <= nxt_state != ST_IDLE;
      taken_ff   <= send_item;
      refused_ff <= refuse;
      aborted_ff <= abort;
      mismatch_ff <= abort && error_cause_in == MISMATCH_CAUSE;
      if (start_open) begin
        main_sent_ff <= 1'b0;
        fast_sent_ff <= 1'b0;
      end else if (send_item) begin
        if (item_kind_in == KIND_CAP_MAIN) main_sent_ff <= 1'b1;
        if (item_kind_in == KIND_CAP_FAST) fast_sent_ff <= 1'b1;
      end
    end
  end

  assign msg_valid_out             = msg_valid_ff;
  assign msg_type_out              = msg_type_ff;
  assign session_message_count_out = count_ff;
  assign msg_data_out              = data_ff;
  assign item_taken_out            = taken_ff;
  assign item_refused_out          = refused_ff;
  assign session_open_out          = open_ff;
  assign aborted_out               = aborted_ff;
  assign mismatch_out              = mismatch_ff;

  a_item_in_session: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    item_taken_out |-> session_open_out)
    else $error("item sent outside a session");

  a_open_after_query: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (state_ff == ST_IDLE && query_in && out_free) |=>
    (msg_valid_out && msg_type_out == MSG_OPEN))
    else $error("query not answered by opening");

  a_count_bound: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (msg_valid_out && msg_type_out == MSG_OPEN) |->
    session_message_count_out <= MAX_COUNT)
    else $error("announced count above limit");

  a_close_when_done: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    send_close |-> cif.remaining == COUNT_RESET)
    else $error("close before all items sent");

  a_no_extra_item: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    send_item |-> cif.remaining != COUNT_RESET)
    else $error("item beyond announced count");

  a_close_ends: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    send_close |=> !session_open_out)
    else $error("session open after close");

  a_abort_stops: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    abort |=> (state_ff == ST_IDLE && aborted_out))
    else $error("error did not abort session");

  a_cap_once: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (send_item && item_kind_in == KIND_CAP_MAIN) |-> !main_sent_ff)
    else $error("second main capacity message");

  a_cap_in_session: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (send_item && item_kind_in != KIND_OTHER) |-> state_ff == ST_SEND)
    else $error("capacity message outside session");

  a_data_current: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    send_item |=> msg_data_out == $past(item_data_in))
    else $error("item data not current");

  a_valid_holds: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (msg_valid_out && !msg_ready_in && !abort) |=>
    (msg_valid_out && $stable(msg_type_out) &&
     $stable(session_message_count_out)))
    else $error("pending message dropped or changed");

  a_refuse_dup: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (state_ff == ST_SEND && item_valid_in && !abort &&
     item_kind_in == KIND_CAP_MAIN && main_sent_ff) |=>
    (item_refused_out && !item_taken_out))
    else $error("duplicate capacity item not refused");

  a_mismatch_abort: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    mismatch_out |-> aborted_out)
    else $error("mismatch flagged without abort");

  a_open_with_msg: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    $rose(session_open_out) |->
    (msg_valid_out && msg_type_out == MSG_OPEN))
    else $error("session opened without opening message");

  a_count_loaded: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    start_open |=> cif.remaining == session_message_count_out)
    else $error("item counter differs from announced count");
endmodule

// File: include/alloc_session_pkg.sv
package alloc_session_pkg;
  localparam int          COUNT_W       = 10;
  localparam logic [9:0]  MAX_COUNT     = 10'h03E7;
  localparam logic [9:0]  COUNT_RESET   = 10'h0000;
  localparam logic [31:0] MISMATCH_CAUSE = 32'h4E4D_5347;
  localparam logic [1:0]  KIND_OTHER    = 2'h0;
  localparam logic [1:0]  KIND_CAP_MAIN = 2'h1;
  localparam logic [1:0]  KIND_CAP_FAST = 2'h2;
  localparam logic [1:0]  MSG_OPEN      = 2'h0;
  localparam logic [1:0]  MSG_ITEM      = 2'h1;
  localparam logic [1:0]  MSG_CLOSE     = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OPEN = 3'b010,
    ST_SEND = 3'b100
  } sess_state_t;
endpackage

// File: include/item_count_if.sv
`timescale 1ns/1ps
interface item_count_if;
  logic       load;
  logic       step;
  logic [9:0] value;
  logic [9:0] remaining;
  logic       done;
  modport ctrl (output load, output step, output value,
                input remaining, input done);
  modport cnt  (input load, input step, input value,
                output remaining, output done);
endinterface

// File: hdl/item_counter.sv
`timescale 1ns/1ps
module item_counter
  import alloc_session_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  item_count_if.cnt cnt
);
  logic [9:0] remain_ff;
  logic [9:0] nxt_remain;

  assign nxt_remain = cnt.load ? cnt.value :
                      (cnt.step && remain_ff != COUNT_RESET) ?
                      remain_ff - 10'h0001 : remain_ff;
  assign cnt.remaining = remain_ff;
  assign cnt.done      = (remain_ff == COUNT_RESET);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) remain_ff <= COUNT_RESET;
    else remain_ff <= nxt_remain;
  end
endmodule

// File: sim/upstream_model.sv
`timescale 1ns/1ps
module upstream_model
  import alloc_session_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        msg_valid_in,
  input  wire logic [1:0]  msg_type_in,
  input  wire logic [9:0]  count_in,
  input  wire logic        stall_in,
  input  wire logic        err_req_in,
  input  wire logic [31:0] err_cause_in,
  output logic             ready_out,
  output logic             error_out,
  output logic [31:0]      cause_out,
  output logic [9:0]       items_out
);
  logic [9:0] announced_ff;
  logic       mism_ff;
  logic       take;
  assign take = msg_valid_in && ready_out;
  always @(posedge clk_in) begin
    ready_out <= !stall_in;
    error_out <= err_req_in || mism_ff;
    // cause lines only carry meaning with the error strobe
    cause_out <= err_req_in ? err_cause_in :
                 (mism_ff ? MISMATCH_CAUSE : ~cause_out);
    mism_ff <= take && msg_type_in == MSG_CLOSE &&
               items_out != announced_ff;
    if (take && msg_type_in == MSG_OPEN) begin
      announced_ff <= count_in;
      items_out <= 10'h000;
    end else if (take && msg_type_in == MSG_ITEM)
      items_out <= items_out + 10'h001;
    if (!reset_n_in) begin
      {ready_out, error_out, mism_ff} <= 3'h0;
      cause_out <= 32'h0000_0000;
      items_out <= 10'h000;
      announced_ff <= 10'h000;
    end
  end
endmodule

// File: sim/resource_alloc_session_ctrl_test.sv
`timescale 1ns/1ps
module resource_alloc_session_ctrl_test
  import alloc_session_pkg::*;
;
  logic        clk_in, reset_n_in, query, err_req, stall, item_valid;
  logic        error, ready, mvalid, taken, refused, sopen, aborted, mism;
  logic [31:0] err_cause, cause, item_data, msg_data;
  logic [9:0]  total, count, items;
  logic [1:0]  kind, mtype;
  int          n_mismatch, n_tests;
  wire  [5:0]  obs = {mism, aborted, refused, taken, sopen, mvalid};
  resource_alloc_session_ctrl resource_alloc_session_ctrl_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .query_in(query),
    .error_in(error), .error_cause_in(cause), .item_total_in(total),
    .item_valid_in(item_valid), .item_kind_in(kind),
    .item_data_in(item_data), .msg_ready_in(ready),
    .msg_valid_out(mvalid), .msg_type_out(mtype),
    .session_message_count_out(count), .msg_data_out(msg_data),
    .item_taken_out(taken), .item_refused_out(refused),
    .session_open_out(sopen), .aborted_out(aborted),
    .mismatch_out(mism));
  upstream_model upstream_model_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .msg_valid_in(mvalid),
    .msg_type_in(mtype), .count_in(count), .stall_in(stall),
    .err_req_in(err_req), .err_cause_in(err_cause), .ready_out(ready),
    .error_out(error), .cause_out(cause), .items_out(items));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wait_for(input int k);
    for (int i = 0; i < 40 && obs[k] !== 1'b1; i++) @(negedge clk_in);
    if (obs[k] !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t wait expired", $time);
      conclude();
    end
  endtask
  task open_session(input logic [9:0] n, input logic [9:0] exp);
    total = n;
    query = 1'b1;
    @(negedge clk_in);
    query = 1'b0;
    wait_for(0);
    chk(mtype, MSG_OPEN);
    chk(count, exp);
    chk(sopen, 1'b1);
  endtask
  task send_item(input logic [1:0] k, input logic [31:0] d, input int w);
    item_valid = 1'b1;
    kind = k;
    item_data = d;
    wait_for(w);
    if (w == 2) begin
      chk(mtype, MSG_ITEM);
      chk(msg_data, d);
    end else
      chk(taken, 1'b0);
    item_valid = 1'b0;
    @(negedge clk_in);
  endtask
  task expect_close(input logic [9:0] n);
    for (int i = 0; i < 40 && !(mvalid && mtype === MSG_CLOSE); i++)
      @(negedge clk_in);
    if (!(mvalid === 1'b1 && mtype === MSG_CLOSE)) begin
      n_mismatch++;
      $display("[ERR] %0t close never seen", $time);
      conclude();
    end
    chk(mtype, MSG_CLOSE);
    repeat (3) @(negedge clk_in);
    chk(items, n);
    chk(sopen, 1'b0);
    chk(error, 1'b0);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    {reset_n_in, query, err_req, stall, item_valid, kind} = 7'h00;
    {n_mismatch, n_tests, total, item_data, err_cause} = '0;
    repeat (10) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    // open message must stand while the link stalls
    stall = 1'b1;
    open_session(10'h003, 10'h003);
    repeat (2) @(negedge clk_in);
    chk(obs[1:0], 2'h3);
    stall = 1'b0;
    send_item(KIND_OTHER, 32'hA5A5_0001, 2);
    send_item(KIND_CAP_MAIN, 32'hA5A5_0002, 2);
    send_item(KIND_CAP_FAST, 32'hA5A5_0003, 2);
    expect_close(10'h003);
    open_session(10'h002, 10'h002);
    send_item(KIND_CAP_MAIN, 32'h0000_0011, 2);
    send_item(KIND_CAP_MAIN, 32'h0000_0012, 3);
    send_item(KIND_CAP_FAST, 32'h0000_0013, 2);
    expect_close(10'h002);
    open_session(10'h000, 10'h000);
    expect_close(10'h000);
    open_session(10'h03FF, MAX_COUNT);
    send_item(KIND_OTHER, 32'h0000_0021, 2);
    err_req = 1'b1;
    err_cause = MISMATCH_CAUSE;
    @(negedge clk_in);
    err_req = 1'b0;
    wait_for(4);
    chk(mism, 1'b1);
    @(negedge clk_in);
    chk(obs[1:0], 2'h0);
    item_valid = 1'b1;
    repeat (4) begin
      @(negedge clk_in);
      chk(obs[2:0], 3'h0);
    end
    item_valid = 1'b0;
    // error seen in the cycle right after opening must abort as well
    err_req = 1'b1;
    open_session(10'h001, 10'h001);
    err_req = 1'b0;
    wait_for(4);
    chk(obs[1:0], 2'h0);
    conclude();
  end
endmodule
